/* hdl/tkm_touch_key.v */
// touch key measurement unit with its interrupt control register
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tkm_map.vh"
// Notes on behaviour
// RQ1: count selected pad oscillator cycles during a reference-timed period
// RQ2: four pad inputs, each with its own sense oscillator
// RQ3: pin-select bits decide whether each pin acts as touch input
// RQ4: start low clears cycle, function and unit counters, not slot counter
// RQ5: start rising edge runs all counters and enables oscillators
// RQ6: slot overflow stops oscillators and all counters
// RQ7: slot clock is reference oscillator or system clock over four
// RQ8: slot select 0 picks reference, 1 picks system clock over four
// RQ9: reference and key oscillators run only while their enables are set
// RQ10: one interrupt at slot overflow, considering only enabled pads
// RQ11: at the interrupt, cycle, function, unit and slot counters clear
// RQ12: slot overflow flag sets on overflow, raises irq, software clears
// RQ13: cycle counter overflow flag is sticky until software clears
// RQ14: function counter overflow flag is sticky until software clears
// RQ15: touch request flag at bit 6, touch enable at bit 3
// RQ16: global enable at bit 0, one enables
// RQ17: flag with enable low stays set and raises no interrupt
// RQ18: servicing clears global enable; new requests still set flags
// RQ19: irq goes out only when flag, enable and global enable all set
// RQ20: software writes to flags take effect directly, zero clears, one sets
module tkm_touch_key #(
    parameter NUM_KEYS = 4,
    parameter CNT_W = 16,
    parameter UNIT_W = 5,
    parameter SLOT_W = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // register port
    input wire [`TKM_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // pads and oscillators
    input wire [NUM_KEYS-1:0] sense_pad_inputs,
    input wire ref_osc_in,
    output reg [NUM_KEYS-1:0] key_osc_run,
    output reg ref_osc_run,
    output reg [NUM_KEYS-1:0] pad_touch_mode,
    // cpu interrupt side
    input wire irq_service,
    output wire touch_irq_req
);
    // registers
    reg [7:0] touch_ctrl_one;
    reg measure_go;
    reg slot_overflow_flag;
    reg cycle_overflow_flag;
    reg func_overflow_flag;
    reg [1:0] key_sel;
    reg [SLOT_W-1:0] slot_preset;
    reg touch_irq_flag;
    reg touch_irq_enable;
    reg global_irq_enable;
    // measurement state
    reg go_d;
    reg running;
    reg [UNIT_W-1:0] unit_cnt;
    reg [SLOT_W-1:0] slot_cnt;
    reg [1:0] div4;
    reg ref_d;
    wire [NUM_KEYS-1:0] pad_sync;
    wire ref_sync;
    wire [CNT_W-1:0] cyc_cnt;
    wire [CNT_W-1:0] func_cnt;
    wire cyc_wrap;
    wire func_wrap;
    wire slot_tick;
    wire unit_wrap;
    wire slot_ovf;
    wire sel_pad;
    wire wr_c0;
    wire wr_ic;
    wire ic_wen;

    function wr_hit;
        input [`TKM_ADDR_W-1:0] addr;
        input [`TKM_ADDR_W-1:0] ofs;
        input strobe;
        begin
            wr_hit = strobe && (addr == ofs);
        end
    endfunction

    // pad and reference levels come from other clock domains
    tkm_sync #(.WIDTH(NUM_KEYS + 1)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({ref_osc_in, sense_pad_inputs}),
        .sync_out({ref_sync, pad_sync})
    );

    // only an enabled pad in touch mode feeds the count
    assign sel_pad = pad_sync[key_sel] & touch_ctrl_one[key_sel] &
        pad_touch_mode[key_sel]; // RQ10 RQ3

    // cycle counter on the selected key oscillator
    tkm_edge_count #(.WIDTH(CNT_W)) u_cyc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clear(!measure_go || slot_ovf), // RQ4 RQ11
        .run(running),
        .level(sel_pad), // RQ1
        .count(cyc_cnt),
        .wrap(cyc_wrap)
    );

    // function counter on the slot clock
    tkm_edge_count #(.WIDTH(CNT_W)) u_func (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clear(!measure_go || slot_ovf), // RQ4 RQ11
        .run(running),
        .level(slot_tick),
        .count(func_cnt),
        .wrap(func_wrap)
    );

    // slot clock: reference edge or every fourth system clock
    assign slot_tick = touch_ctrl_one[`TKM_C1_SLOT_SEL] ?
        (div4 == 2'h3) : (ref_sync & ~ref_d); // RQ7 RQ8
    // widen the unit count so the compare against the length is exact
    assign unit_wrap = running && slot_tick &&
        ({{(32-UNIT_W){1'b0}}, unit_cnt} == `TKM_UNIT_LEN - 1);
    assign slot_ovf = unit_wrap && (&slot_cnt); // RQ1

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div4 <= 2'h0;
            ref_d <= 1'b0;
        end else begin
            div4 <= div4 + 2'h1;
            ref_d <= ref_sync;
        end
    end

    // measurement sequencing
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            go_d <= 1'b0;
            running <= 1'b0;
            unit_cnt <= {UNIT_W{1'b0}};
            slot_cnt <= {SLOT_W{1'b0}};
        end else begin
            go_d <= measure_go;
            if (!measure_go) begin
                running <= 1'b0;
                unit_cnt <= {UNIT_W{1'b0}}; // RQ4
            end else if (!go_d) begin
                running <= 1'b1; // RQ5
                unit_cnt <= {UNIT_W{1'b0}};
                slot_cnt <= slot_preset;
            end else if (slot_ovf) begin
                running <= 1'b0; // RQ6
                unit_cnt <= {UNIT_W{1'b0}}; // RQ11
                slot_cnt <= {SLOT_W{1'b0}}; // RQ11
            end else if (running && slot_tick) begin
                unit_cnt <= unit_cnt + {{(UNIT_W-1){1'b0}}, 1'b1};
                if (unit_wrap)
                    slot_cnt <= slot_cnt + {{(SLOT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // oscillator enables follow the run state and their own bits
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            key_osc_run <= {NUM_KEYS{1'b0}};
            ref_osc_run <= 1'b0;
        end else begin
            ref_osc_run <= touch_ctrl_one[`TKM_C1_REF_ON] &&
                measure_go && (running || !go_d) && !slot_ovf; // RQ9 RQ6 RQ5
            key_osc_run <= (touch_ctrl_one[`TKM_C1_KEY_ON] &&
                measure_go && (running || !go_d) && !slot_ovf) ?
                touch_ctrl_one[NUM_KEYS-1:0] : {NUM_KEYS{1'b0}}; // RQ9 RQ2
        end
    end

    // register writes; hardware set wins over a software clear
    assign wr_c0 = wr_hit(reg_addr, `TKM_OFS_CTRL_ZERO, reg_wr);
    assign wr_ic = wr_hit(reg_addr, `TKM_OFS_IRQ_CTRL, reg_wr);
    assign ic_wen = wr_ic;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            touch_ctrl_one <= `TKM_RST_BYTE;
            measure_go <= 1'b0;
            slot_overflow_flag <= 1'b0;
            cycle_overflow_flag <= 1'b0;
            func_overflow_flag <= 1'b0;
            key_sel <= 2'h0;
            slot_preset <= {SLOT_W{1'b0}};
            pad_touch_mode <= {NUM_KEYS{1'b0}};
        end else begin
            if (wr_hit(reg_addr, `TKM_OFS_CTRL_ONE, reg_wr))
                touch_ctrl_one <= reg_wdata & `TKM_C1_MASK;
            if (wr_hit(reg_addr, `TKM_OFS_SLOT_PRESET, reg_wr))
                slot_preset <= reg_wdata[SLOT_W-1:0];
            if (wr_hit(reg_addr, `TKM_OFS_PIN_SEL, reg_wr))
                pad_touch_mode <= reg_wdata[NUM_KEYS-1:0]; // RQ3
            if (wr_c0) begin
                measure_go <= reg_wdata[`TKM_C0_GO];
                key_sel <= reg_wdata[`TKM_C0_SEL_LSB +: 2];
            end
            slot_overflow_flag <= slot_ovf ? 1'b1 :
                wr_c0 ? reg_wdata[`TKM_C0_SLOT_OV] :
                slot_overflow_flag; // RQ12 RQ20
            cycle_overflow_flag <= cyc_wrap ? 1'b1 :
                wr_c0 ? reg_wdata[`TKM_C0_CYC_OV] :
                cycle_overflow_flag; // RQ13 RQ20
            func_overflow_flag <= func_wrap ? 1'b1 :
                wr_c0 ? reg_wdata[`TKM_C0_FUNC_OV] :
                func_overflow_flag; // RQ14 RQ20
        end
    end

    // first interrupt control register, touch bits only
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            touch_irq_flag <= 1'b0;
            touch_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end else begin
            // flag is kept even when disabled
            touch_irq_flag <= slot_ovf ? 1'b1 :
                ic_wen ? reg_wdata[`TKM_IC_FLAG] :
                touch_irq_flag; // RQ10 RQ12 RQ17 RQ18 RQ20
            if (ic_wen)
                touch_irq_enable <= reg_wdata[`TKM_IC_EN]; // RQ15
            if (irq_service)
                global_irq_enable <= 1'b0; // RQ18
            else if (ic_wen)
                global_irq_enable <= reg_wdata[`TKM_IC_GIE]; // RQ16
        end
    end

    assign touch_irq_req = touch_irq_flag & touch_irq_enable &
        global_irq_enable; // RQ19 RQ17

    // read data one cycle after the strobe, zero otherwise
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `TKM_OFS_CTRL_ONE: reg_rdata <= touch_ctrl_one;
                `TKM_OFS_CTRL_ZERO: reg_rdata <= {measure_go,
                    slot_overflow_flag, cycle_overflow_flag,
                    func_overflow_flag, 2'h0, key_sel};
                `TKM_OFS_SLOT_PRESET: reg_rdata <= slot_preset;
                `TKM_OFS_CYC_LO: reg_rdata <= cyc_cnt[7:0];
                `TKM_OFS_CYC_HI: reg_rdata <= cyc_cnt[15:8];
                `TKM_OFS_FUNC_LO: reg_rdata <= func_cnt[7:0];
                `TKM_OFS_FUNC_HI: reg_rdata <= func_cnt[15:8];
                `TKM_OFS_IRQ_CTRL: reg_rdata <= {1'b0, touch_irq_flag,
                    2'h0, touch_irq_enable, 2'h0, global_irq_enable};
                `TKM_OFS_PIN_SEL: reg_rdata <= {{(8-NUM_KEYS){1'b0}},
                    pad_touch_mode};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

/* hdl/tkm_map.vh */
// register offsets, field positions and timing constants of the touch unit
`ifndef TKM_MAP_VH
`define TKM_MAP_VH
// register offsets (8-bit registers on a plain port)
`define TKM_ADDR_W 4
`define TKM_OFS_CTRL_ONE 4'h0
`define TKM_OFS_CTRL_ZERO 4'h1
`define TKM_OFS_SLOT_PRESET 4'h2
`define TKM_OFS_CYC_LO 4'h3
`define TKM_OFS_CYC_HI 4'h4
`define TKM_OFS_FUNC_LO 4'h5
`define TKM_OFS_FUNC_HI 4'h6
`define TKM_OFS_IRQ_CTRL 4'h7
`define TKM_OFS_PIN_SEL 4'h8
// touch_ctrl_one fields
`define TKM_C1_SLOT_SEL 7
`define TKM_C1_REF_ON 5
`define TKM_C1_KEY_ON 4
`define TKM_C1_MASK 8'hbf
// control-zero fields (own layout)
`define TKM_C0_GO 7
`define TKM_C0_SLOT_OV 6
`define TKM_C0_CYC_OV 5
`define TKM_C0_FUNC_OV 4
`define TKM_C0_SEL_LSB 0
// irq_control_zero fields
`define TKM_IC_FLAG 6
`define TKM_IC_EN 3
`define TKM_IC_GIE 0
`define TKM_IC_MASK 8'h48
// reset values
`define TKM_RST_BYTE 8'h00
// timing
`define TKM_SYS_DIV 4
`define TKM_UNIT_LEN 32
`endif

/* hdl/tkm_sync.v */
// two-flop synchroniser for pad and reference oscillator levels
`timescale 1ns/1ns
`default_nettype none
module tkm_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage_one <= {WIDTH{1'b0}};
            stage_two <= {WIDTH{1'b0}};
        end else begin
            stage_one <= async_in;
            stage_two <= stage_one;
        end
    end

    assign sync_out = stage_two;
endmodule
`default_nettype wire

/* hdl/tkm_edge_count.v */
// 16-bit edge counter with overflow pulse, cleared while idle
`timescale 1ns/1ns
`default_nettype none
module tkm_edge_count #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // control
    input wire clear,
    input wire run,
    input wire level,
    // result
    output reg [WIDTH-1:0] count,
    output wire wrap
);
    reg level_d;
    wire rise;

    assign rise = level & ~level_d;
    assign wrap = run & rise & (&count);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            level_d <= 1'b0;
            count <= {WIDTH{1'b0}};
        end else begin
            level_d <= level;
            if (clear)
                count <= {WIDTH{1'b0}};
            else if (run && rise)
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

/* verif/tkm_touch_key_asserts.sv */
// port assertions for the touch key unit
`timescale 1ns/1ns
`default_nettype none
`include "tkm_map.vh"
module tkm_touch_key_asserts #(
    parameter NUM_KEYS = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [`TKM_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // oscillators and interrupt
    input wire logic [NUM_KEYS-1:0] key_osc_run,
    input wire logic ref_osc_run,
    input wire logic [NUM_KEYS-1:0] pad_touch_mode,
    input wire logic irq_service,
    input wire logic touch_irq_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire irq_wr = reg_wr && reg_addr == `TKM_OFS_IRQ_CTRL;
    property p_unmapped;
        reg_rd && reg_addr > `TKM_OFS_PIN_SEL |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_ic_read;
        reg_rd && reg_addr == `TKM_OFS_IRQ_CTRL |=> (reg_rdata & 8'hb6) == 8'h00;
    endproperty
    a_ic_read: assert property (p_ic_read) else $error("irq ctrl bits");
    property p_c1_gap;
        reg_rd && reg_addr == `TKM_OFS_CTRL_ONE |=> !reg_rdata[6];
    endproperty
    a_c1_gap: assert property (p_c1_gap) else $error("ctrl one bit6");
    property p_pin;
        reg_wr && reg_addr == `TKM_OFS_PIN_SEL
            |=> pad_touch_mode == $past(reg_wdata[NUM_KEYS-1:0]);
    endproperty
    a_pin: assert property (p_pin) else $error("pin select");
    property p_irq_on;
        irq_wr && !irq_service && reg_wdata[6] && reg_wdata[3] && reg_wdata[0]
            |=> touch_irq_req;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq not raised");
    property p_gie_off;
        irq_wr && !reg_wdata[0] |=> !touch_irq_req;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("irq global");
    property p_en_off;
        irq_wr && !reg_wdata[3] |=> !touch_irq_req;
    endproperty
    a_en_off: assert property (p_en_off) else $error("irq enable");
    property p_service;
        irq_service ##1 !irq_wr |-> !touch_irq_req ##1 !touch_irq_req;
    endproperty
    a_service: assert property (p_service) else $error("irq service");
    property p_osc_stop;
        $rose(touch_irq_req) && !$past(reg_wr)
            |-> key_osc_run == '0 && !ref_osc_run;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("osc running");
    c_irq: cover property ($rose(touch_irq_req));
    c_service: cover property (irq_service && touch_irq_req);
    c_unmapped: cover property (reg_rd && reg_addr > `TKM_OFS_PIN_SEL);
endmodule
bind tkm_touch_key tkm_touch_key_asserts #(.NUM_KEYS(NUM_KEYS)) chk_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .key_osc_run(key_osc_run),
    .ref_osc_run(ref_osc_run), .pad_touch_mode(pad_touch_mode),
    .irq_service(irq_service), .touch_irq_req(touch_irq_req));
`default_nettype wire

/* verif/tkm_pad_model.sv */
// behavioural pad and reference oscillators
`timescale 1ns/1ns
`default_nettype none
module tkm_pad_model #(
    parameter int REF_HALF = 500
) (
    // enables from the unit
    input wire logic [3:0] key_osc_run,
    input wire logic ref_osc_run,
    // levels to the unit
    output logic [3:0] sense_pad_inputs,
    output logic ref_osc_in
);
    logic [3:0] odd_pads = 4'h0;
    logic [3:0] even_pads = 4'h0;
    initial ref_osc_in = 1'b0;
    // pads 0 and 2 share one period, pads 1 and 3 another; a stopped one holds its level
    // periods chosen so no toggle lands on a rising clock edge
    always begin
        #180;
        odd_pads = odd_pads ^ (key_osc_run & 4'h5);
    end
    always begin
        #240;
        even_pads = even_pads ^ (key_osc_run & 4'ha);
    end
    always begin
        #(REF_HALF);
        if (ref_osc_run) ref_osc_in = ~ref_osc_in;
    end
    assign sense_pad_inputs = (odd_pads & 4'h5) | (even_pads & 4'ha);
endmodule
`default_nettype wire

/* verif/test_tkm_touch_key.sv */
// self-checking bench for the touch key unit
`timescale 1ns/1ns
`default_nettype none
`include "tkm_map.vh"
module test_tkm_touch_key;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic irq_service = 1'b0;
    wire logic [7:0] reg_rdata;
    wire logic [3:0] sense_pad_inputs, key_osc_run, pad_touch_mode;
    wire logic ref_osc_in, ref_osc_run, touch_irq_req;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    always #50 clk_sys = ~clk_sys;
    tkm_touch_key tkm_touch_key_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sense_pad_inputs(sense_pad_inputs), .ref_osc_in(ref_osc_in),
        .key_osc_run(key_osc_run), .ref_osc_run(ref_osc_run),
        .pad_touch_mode(pad_touch_mode), .irq_service(irq_service),
        .touch_irq_req(touch_irq_req));
    tkm_pad_model tkm_pad_model_i (.key_osc_run(key_osc_run),
        .ref_osc_run(ref_osc_run), .sense_pad_inputs(sense_pad_inputs),
        .ref_osc_in(ref_osc_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic fetch(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
            input logic [7:0] m = 8'hff);
        logic [7:0] v;
        fetch(a, v);
        check({8'h00, v & m}, {8'h00, e});
    endtask
    // oscillators sampled mid-run, then wait for the request
    task automatic measure(input logic [7:0] c1);
        logic [7:0] got;
        wr(`TKM_OFS_CTRL_ONE, c1);
        wr(`TKM_OFS_SLOT_PRESET, 8'hfe);
        wr(`TKM_OFS_IRQ_CTRL, 8'h09);
        wr(`TKM_OFS_CTRL_ZERO, 8'h80);
        n = 0;
        while (touch_irq_req !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n == 10) check({11'h0, key_osc_run, ref_osc_run}, {11'h0, 4'h1, c1[5]});
            if (n == 100) begin
                // counts vanish at the interrupt, so look mid-run
                fetch(`TKM_OFS_CYC_LO, got);
                check({15'h0, got != 8'h00}, 16'h0001);
            end
        end
    endtask
    // generous ceiling: whole run is near 1100 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`TKM_OFS_CTRL_ONE, 8'h00);
        rd(`TKM_OFS_IRQ_CTRL, 8'h00);
        rd(4'hf, 8'h00);
        wr(`TKM_OFS_CTRL_ONE, 8'hff);
        rd(`TKM_OFS_CTRL_ONE, 8'hbf);
        wr(`TKM_OFS_PIN_SEL, 8'h0f);
        check({12'h0, pad_touch_mode}, 16'h000f);
        wr(`TKM_OFS_IRQ_CTRL, 8'h48);
        rd(`TKM_OFS_IRQ_CTRL, 8'h48);
        check({15'h0, touch_irq_req}, 16'h0000);
        wr(`TKM_OFS_IRQ_CTRL, 8'h49);
        check({15'h0, touch_irq_req}, 16'h0001);
        @(posedge clk_sys);
        irq_service <= 1'b1;
        @(posedge clk_sys);
        irq_service <= 1'b0;
        rd(`TKM_OFS_IRQ_CTRL, 8'h48);
        check({15'h0, touch_irq_req}, 16'h0000);
        wr(`TKM_OFS_IRQ_CTRL, 8'h00);
        rd(`TKM_OFS_IRQ_CTRL, 8'h00);
        measure(8'h91);
        check({15'h0, n >= 250 && n <= 270}, 16'h0001);
        check({11'h0, key_osc_run, ref_osc_run}, 16'h0000);
        rd(`TKM_OFS_CTRL_ZERO, 8'h40, 8'h40);
        rd(`TKM_OFS_IRQ_CTRL, 8'h49);
        for (int a = 3; a < 7; a++) rd(a[3:0], 8'h00);
        repeat (20) @(posedge clk_sys);
        rd(`TKM_OFS_CTRL_ZERO, 8'h40, 8'h40);
        wr(`TKM_OFS_CTRL_ZERO, 8'h00);
        rd(`TKM_OFS_CTRL_ZERO, 8'h00);
        wr(`TKM_OFS_CTRL_ZERO, 8'h70);
        repeat (5) @(posedge clk_sys);
        rd(`TKM_OFS_CTRL_ZERO, 8'h70);
        wr(`TKM_OFS_CYC_LO, 8'h55);
        for (int a = 3; a < 7; a++) rd(a[3:0], 8'h00);
        measure(8'h31);
        check({15'h0, n >= 620 && n <= 680}, 16'h0001);
        // third run: select a disabled pad, then stop it early
        wr(`TKM_OFS_CTRL_ZERO, 8'h00);
        wr(`TKM_OFS_CTRL_ONE, 8'hb1);
        wr(`TKM_OFS_CTRL_ZERO, 8'h81);
        repeat (50) @(posedge clk_sys);
        rd(`TKM_OFS_CTRL_ZERO, 8'h81);
        rd(`TKM_OFS_CYC_LO, 8'h00);
        wr(`TKM_OFS_CTRL_ZERO, 8'h00);
        for (int a = 3; a < 7; a++) rd(a[3:0], 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
